// ---- verilog/mcrc_clock_reset.sv ----
// Purpose: clock generation and reset control of the ethernet-to-wan mapper
// Assumes: aclk is the continuous system clock, all pin inputs synchronous to it
// Notes:   registers sit on axi4-lite in the global window 0f0h..0ffh
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "mcrc_consts.svh"

module mcrc_clock_reset
  import mcrc_pkg::*;
#(
  parameter int RESET_SETTLE_CYCLES = `MCRC_RESET_SETTLE_CYC
)
(
  // clock and reset pin
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address and data
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [9:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // configuration pins
  input  wire logic        reduced_interface_select,
  input  wire logic [1:0]  host_bus_style_select,
  input  wire logic        test_port_reset_pin_n,
  // clock inputs sampled on aclk
  input  wire logic        reference_clock_in,
  input  wire logic        serial_tx_line_clock,
  input  wire logic        serial_rx_line_clock,
  // generated clocks
  output logic             memory_clock_out,
  output logic             divided_reference_out,
  output logic             management_clock_out,
  // mii clock pins
  input  wire logic        mii_tx_clk_in,
  input  wire logic        mii_rx_clk_in,
  output mcrc_mii_pins_t   mii_pins,
  // clocks toward the mac and serial port
  output logic             mac_tx_timing,
  output logic             mac_rx_timing,
  output logic             serial_tx_edge,
  output logic             serial_rx_edge,
  // resets toward the rest of the device
  output logic             global_reset_n,
  output logic             low_power,
  output logic             serial_reset,
  output logic             serial_powerdown,
  output logic             queue_pointer_reset,
  output logic             scan_port_reset,
  output logic             host_bus_oe_n,
  output logic             host_bus_intel,
  output logic             host_bus_motorola,
  output logic             reset_done
);

  mcrc_state_t st;
  mcrc_state_t next_st;
  logic        glob;

  // map an address in the global window to a register
  function automatic mcrc_sel_t reg_sel(input logic [9:0] addr);
    mcrc_sel_t s;
    s = SEL_NONE;
    if (addr[9:2] == `MCRC_ADDR_CTL_ONE >> 2)
      s = SEL_CTL;
    else if (addr[9:2] == `MCRC_ADDR_SERIAL_RST >> 2)
      s = SEL_SER;
    else if (addr[9:2] == `MCRC_ADDR_QPTR_RST >> 2)
      s = SEL_QPTR;
    else if (addr[9:2] == `MCRC_ADDR_STATUS >> 2)
      s = SEL_STS;
    return s;
  endfunction

  // bus style decode, 00 and 01 are the only defined codes
  function automatic logic [1:0] style_dec(input logic [1:0] code);
    logic [1:0] d;
    d = 2'h0;
    if (code == `MCRC_STYLE_INTEL)
      d = 2'h1;
    else if (code == `MCRC_STYLE_MOTOROLA)
      d = 2'h2;
    return d;
  endfunction

  // global reset from the software bit; the pin acts in the clocked process
  assign glob = st.sw_reset;

  // next state of the whole block
  always_comb
  begin
    logic [31:0] rword;
    logic [1:0]  refhalf;
    logic        mii_mode;
    logic        ref_rise;
    mcrc_sel_t   wsel;
    mcrc_sel_t   rsel;
    rword    = 32'h0;
    refhalf  = 2'h0;
    mii_mode = 1'b0;
    ref_rise = 1'b0;
    wsel     = SEL_NONE;
    rsel     = SEL_NONE;
    next_st  = st;
    next_st.qptr_pulse = 1'b0;

    // configuration pins are followed every cycle
    next_st.rmii  = reduced_interface_select;
    next_st.style = host_bus_style_select;
    mii_mode = ~st.rmii;

    // reference output, half period 1 or 2 cycles
    refhalf = st.rmii ? 2'(`MCRC_REF_DIV_RMII / 2)
                      : 2'(`MCRC_REF_DIV_MII / 2);
    if (st.ref_off || glob)
    begin
      next_st.ref_cnt = 2'h0;
      next_st.ref_out = 1'b0;
    end
    else if (st.ref_cnt + 2'h1 >= refhalf)
    begin
      next_st.ref_cnt = 2'h0;
      next_st.ref_out = ~st.ref_out;
    end
    else
    begin
      next_st.ref_cnt = st.ref_cnt + 2'h1;
    end

    // management clock divider
    if (glob)
    begin
      next_st.mdc_cnt = 8'h0;
      next_st.mdc_out = 1'b0;
    end
    else if (st.mdc_cnt == 8'(`MCRC_MDC_HALF - 1))
    begin
      next_st.mdc_cnt = 8'h0;
      next_st.mdc_out = ~st.mdc_out;
    end
    else
    begin
      next_st.mdc_cnt = st.mdc_cnt + 8'h1;
    end

    // mii clocks in dce mode follow or divide the reference input
    next_st.refin_smp = reference_clock_in;
    ref_rise = reference_clock_in & ~st.refin_smp;
    if (glob || !mii_mode || !st.dce)
    begin
      next_st.mii_cnt = 3'h0;
      next_st.mii_out = 1'b0;
    end
    else if (st.speed100)
    begin
      next_st.mii_out = reference_clock_in;
    end
    else if (ref_rise)
    begin
      if (st.mii_cnt == 3'(`MCRC_MII_SLOW_DIV / 2 - 1))
      begin
        next_st.mii_cnt = 3'h0;
        next_st.mii_out = ~st.mii_out;
      end
      else
      begin
        next_st.mii_cnt = st.mii_cnt + 3'h1;
      end
    end

    // dte mode: the phy clocks are taken in
    next_st.mii_tx_smp = mii_tx_clk_in;
    next_st.mii_rx_smp = mii_rx_clk_in;

    // serial line clocks: edges only, no reliance on a free-running clock
    next_st.ser_tx_smp  = serial_tx_line_clock;
    next_st.ser_rx_smp  = serial_rx_line_clock;
    next_st.ser_tx_edge = serial_tx_line_clock & ~st.ser_tx_smp & ~st.serial_rst;
    next_st.ser_rx_edge = serial_rx_line_clock & ~st.ser_rx_smp & ~st.serial_rst;

    // reset completion sequencing
    case (st.rphase)
      RS_ACTIVE:
      begin
        next_st.settle_cnt = 20'h0;
        if (!glob)
          next_st.rphase = RS_SETTLE;
      end
      RS_SETTLE:
      begin
        if (glob)
          next_st.rphase = RS_ACTIVE;
        else if (st.settle_cnt >= 20'(RESET_SETTLE_CYCLES - 1))
          next_st.rphase = RS_READY;
        else
          next_st.settle_cnt = st.settle_cnt + 20'h1;
      end
      RS_READY:
      begin
        if (glob)
          next_st.rphase = RS_ACTIVE;
      end
      default:
      begin
        next_st.rphase = RS_ACTIVE;
      end
    endcase

    // axi write address and data, accepted in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_st.aw_got = 1'b1;
      next_st.waddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;

    // perform the write once both halves are held
    if (st.aw_got && st.w_got)
    begin
      wsel = reg_sel(st.waddr);
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = (wsel == SEL_NONE) ? `MCRC_RESP_SLVERR : `MCRC_RESP_OKAY;
      if (st.wstrb[0])
      begin
        case (wsel)
          SEL_CTL:
          begin
            next_st.sw_reset = st.wdata[`MCRC_CTL_SW_RESET];
            next_st.ref_off  = st.wdata[`MCRC_CTL_REF_OFF];
            next_st.dce      = st.wdata[`MCRC_CTL_DCE];
            next_st.speed100 = st.wdata[`MCRC_CTL_SPEED100];
          end
          SEL_SER:
          begin
            next_st.serial_rst = st.wdata[0];
          end
          SEL_QPTR:
          begin
            next_st.qptr_pulse = 1'b1;
          end
          default:
          begin
            next_st.qptr_pulse = 1'b0;
          end
        endcase
      end
    end

    // axi read, one outstanding
    if (st.rvalid && s_axi_rready)
      next_st.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rsel = reg_sel(s_axi_araddr);
      case (rsel)
        SEL_CTL:
        begin
          rword[`MCRC_CTL_SW_RESET] = st.sw_reset;
          rword[`MCRC_CTL_REF_OFF]  = st.ref_off;
          rword[`MCRC_CTL_DCE]      = st.dce;
          rword[`MCRC_CTL_SPEED100] = st.speed100;
        end
        SEL_SER:
        begin
          rword[0] = st.serial_rst;
        end
        SEL_STS:
        begin
          rword[`MCRC_STS_RMII]                        = st.rmii;
          rword[`MCRC_STS_STYLE_LO + 1:`MCRC_STS_STYLE_LO] = st.style;
          rword[`MCRC_STS_RESET_DONE]                  = (st.rphase == RS_READY);
          rword[`MCRC_STS_GLOBAL_RST]                  = glob;
          rword[`MCRC_STS_MOTOROLA:`MCRC_STS_INTEL]    = style_dec(st.style);
        end
        default:
        begin
          rword = 32'h0;
        end
      endcase
      next_st.rvalid = 1'b1;
      next_st.rdata  = rword;
      next_st.rresp  = (rsel == SEL_NONE) ? `MCRC_RESP_SLVERR : `MCRC_RESP_OKAY;
    end

    // global reset returns all but its own bit, the bus slave, the pin samplers and the serial line edges
    if (glob)
    begin
      next_st.ref_off    = 1'b0;
      next_st.dce        = 1'b0;
      next_st.speed100   = 1'b0;
      next_st.serial_rst = 1'b0;
      next_st.qptr_pulse = 1'b0;
    end

    // serial reset returns the serial port state
    if (st.serial_rst)
    begin
      next_st.ser_tx_edge = 1'b0;
      next_st.ser_rx_edge = 1'b0;
    end
  end

  // state register, the pin clears everything including the software bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // axi handshakes
  assign s_axi_awready = ~st.aw_got & ~st.bvalid;
  assign s_axi_wready  = ~st.w_got & ~st.bvalid;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = ~st.rvalid;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;

  // clock outputs
  assign memory_clock_out      = aclk;
  assign divided_reference_out = st.ref_out;
  assign management_clock_out  = st.mdc_out;

  // mii pins drive only in mii dce mode, released otherwise
  assign mii_pins.tx_out  = st.mii_out;
  assign mii_pins.rx_out  = st.mii_out;
  assign mii_pins.tx_oe_n = ~(st.dce & ~st.rmii & ~glob);
  assign mii_pins.rx_oe_n = ~(st.dce & ~st.rmii & ~glob);

  // mac timing: reference in rmii, own clock in dce, phy clock in dte
  assign mac_tx_timing = st.rmii ? st.refin_smp
                                 : (st.dce ? st.mii_out : st.mii_tx_smp);
  assign mac_rx_timing = st.rmii ? st.refin_smp
                                 : (st.dce ? st.mii_out : st.mii_rx_smp);

  // serial line clock edges
  assign serial_tx_edge = st.ser_tx_edge;
  assign serial_rx_edge = st.ser_rx_edge;

  // resets and power states
  assign global_reset_n      = aresetn & ~glob;
  assign low_power           = ~aresetn | glob;
  assign serial_reset        = st.serial_rst | ~aresetn | glob;
  assign serial_powerdown    = st.serial_rst;
  assign queue_pointer_reset = st.qptr_pulse;
  assign scan_port_reset     = ~test_port_reset_pin_n;
  assign host_bus_oe_n       = ~aresetn;
  assign {host_bus_motorola, host_bus_intel} = style_dec(st.style);
  assign reset_done          = (st.rphase == RS_READY);

endmodule

`default_nettype wire

// ---- verilog/mcrc_consts.svh ----
// Purpose: constants for the mapper clock and reset control block
// Assumes: byte addresses on a 32-bit AXI4-Lite register bus
// Notes:   times are kept in their own unit, cycle counts derive from them
`ifndef MCRC_CONSTS_SVH
`define MCRC_CONSTS_SVH

// clock rates
`define MCRC_SYSCLK_KHZ        125000
`define MCRC_SYSCLK_MHZ        125
`define MCRC_MDC_KHZ           1670
`define MCRC_MDC_HALF          (`MCRC_SYSCLK_KHZ / (2 * `MCRC_MDC_KHZ))

// divisors
`define MCRC_REF_DIV_MII       4
`define MCRC_REF_DIV_RMII      2
`define MCRC_MII_SLOW_DIV      10

// reset completion time
`define MCRC_RESET_SETTLE_US   5000
`define MCRC_RESET_SETTLE_CYC  (`MCRC_RESET_SETTLE_US * `MCRC_SYSCLK_MHZ)
`define MCRC_SETTLE_W          20

// register byte addresses, global window 0f0h..0ffh
`define MCRC_GLOBAL_BASE       10'h0f0
`define MCRC_GLOBAL_LAST       10'h0ff
`define MCRC_ADDR_CTL_ONE      10'h0f0
`define MCRC_ADDR_SERIAL_RST   10'h0f4
`define MCRC_ADDR_QPTR_RST     10'h0f8
`define MCRC_ADDR_STATUS       10'h0fc

// global_control_one fields
`define MCRC_CTL_SW_RESET      0
`define MCRC_CTL_REF_OFF       1
`define MCRC_CTL_DCE           2
`define MCRC_CTL_SPEED100      3

// status fields
`define MCRC_STS_RMII          0
`define MCRC_STS_STYLE_LO      1
`define MCRC_STS_RESET_DONE    3
`define MCRC_STS_GLOBAL_RST    4
`define MCRC_STS_INTEL         5
`define MCRC_STS_MOTOROLA      6

// host bus style codes
`define MCRC_STYLE_INTEL       2'h0
`define MCRC_STYLE_MOTOROLA    2'h1

// axi responses
`define MCRC_RESP_OKAY         2'h0
`define MCRC_RESP_SLVERR       2'h2

`endif

// ---- verilog/mcrc_pkg.sv ----
// Purpose: types for the mapper clock and reset control block
// Assumes: constants come from mcrc_consts.svh
// Notes:   the whole block state is one packed struct
package mcrc_pkg;

  // reset sequencing phases
  typedef enum logic [1:0] {RS_ACTIVE, RS_SETTLE, RS_READY} mcrc_rphase_t;

  // register selected by an address
  typedef enum logic [2:0] {SEL_NONE, SEL_CTL, SEL_SER, SEL_QPTR, SEL_STS} mcrc_sel_t;

  // mii clock pins, one group per pin
  typedef struct packed {
    logic tx_out;
    logic tx_oe_n;
    logic rx_out;
    logic rx_oe_n;
  } mcrc_mii_pins_t;

  // complete block state
  typedef struct packed {
    logic               sw_reset;
    logic               ref_off;
    logic               dce;
    logic               speed100;
    logic               serial_rst;
    logic               qptr_pulse;
    logic               rmii;
    logic [1:0]         style;
    logic [1:0]         ref_cnt;
    logic               ref_out;
    logic [7:0]         mdc_cnt;
    logic               mdc_out;
    logic               refin_smp;
    logic [2:0]         mii_cnt;
    logic               mii_out;
    logic               mii_tx_smp;
    logic               mii_rx_smp;
    logic               ser_tx_smp;
    logic               ser_rx_smp;
    logic               ser_tx_edge;
    logic               ser_rx_edge;
    mcrc_rphase_t       rphase;
    logic [19:0]        settle_cnt;
    logic               aw_got;
    logic               w_got;
    logic [9:0]         waddr;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [1:0]         rresp;
    logic [31:0]        rdata;
  } mcrc_state_t;

endpackage

// ---- verif/mcrc_far_model.sv ----
// Purpose: far-side clock sources for the mapper clock and reset block
// Assumes: every clock is counted down from aclk, so all counts are exact
// Notes:   serial clocks stand low while run is low
`timescale 1ns/100ps
`default_nettype none
module mcrc_far_model
(
  // timing and control
  input  wire logic aclk,
  input  wire logic run,
  // clocks toward the block
  output logic      ref_clk,
  output logic      phy_tx,
  output logic      phy_rx,
  output logic      ser_tx,
  output logic      ser_rx
);
  logic [31:0] c = 32'h0;
  logic [31:0] s = 32'h0;

  // free counter, serial counter only within a burst
  always @(posedge aclk)
  begin
    c <= c + 32'h1;
    s <= run ? s + 32'h1 : 32'h0;
  end
  // own reference source, never a loop of the divided output
  assign ref_clk = c[1];
  assign phy_tx  = c[2];
  assign phy_rx  = ~c[2];
  // gapped line clocks, three pulses per 64 cycles
  assign ser_tx  = run && (s[5:3] inside {3'h1, 3'h3, 3'h5});
  assign ser_rx  = run && (s[5:3] inside {3'h1, 3'h3, 3'h5});
endmodule
`default_nettype wire

// ---- verif/mcrc_clock_reset_properties.sv ----
// Purpose: concurrent checks on the ports of the clock and reset block
// Assumes: one aclk domain, aresetn synchronous and active low
// Notes:   helper counters time clock halves and settling
`timescale 1ns/100ps
`default_nettype none
module mcrc_clock_reset_properties
  import mcrc_pkg::*;
#(
  parameter int RESET_SETTLE_CYCLES = 20
)
(
  // clock, reset and pins
  input wire logic           aclk,
  input wire logic           aresetn,
  input wire logic           reduced_interface_select,
  input wire logic           test_port_reset_pin_n,
  input wire logic           serial_tx_line_clock,
  // block outputs
  input wire logic           divided_reference_out,
  input wire logic           management_clock_out,
  input wire mcrc_mii_pins_t mii_pins,
  input wire logic           serial_tx_edge,
  input wire logic           serial_rx_edge,
  input wire logic           global_reset_n,
  input wire logic           low_power,
  input wire logic           serial_reset,
  input wire logic           serial_powerdown,
  input wire logic           queue_pointer_reset,
  input wire logic           scan_port_reset,
  input wire logic           host_bus_oe_n,
  input wire logic           reset_done
);
  logic        mdc_q;
  logic        mdc_seen;
  logic [7:0]  mdc_len;
  logic [31:0] gr_cnt;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // stretch length of the management clock, cycles out of global reset
  always_ff @(posedge aclk)
  begin
    mdc_q <= management_clock_out;
    if (!global_reset_n)
    begin
      mdc_seen <= 1'b0;
      mdc_len  <= 8'h00;
      gr_cnt   <= 32'h0;
    end
    else
    begin
      mdc_seen <= mdc_seen || (management_clock_out != mdc_q);
      mdc_len  <= (management_clock_out != mdc_q) ? 8'h00 : mdc_len + 8'h01;
      gr_cnt   <= (gr_cnt == 32'hffffffff) ? gr_cnt : gr_cnt + 32'h1;
    end
  end

  property p_mdc;
    mdc_seen && (management_clock_out != mdc_q) |-> mdc_len == 8'h24;
  endproperty
  a_mdc: assert property (p_mdc) else $error("mdc half period wrong");
  property p_ref_rmii;
    reduced_interface_select [*4] ##0 $rose(divided_reference_out) |=> !divided_reference_out;
  endproperty
  a_ref_rmii: assert property (p_ref_rmii) else $error("rmii ref not aclk/2");
  property p_ref_hold;
    !global_reset_n [*2] |-> !divided_reference_out;
  endproperty
  a_ref_hold: assert property (p_ref_hold) else $error("ref out runs in reset");
  property p_gr;
    !host_bus_oe_n && (low_power == !global_reset_n);
  endproperty
  a_gr: assert property (p_gr) else $error("low power or bus float wrong");
  property p_ser_rst;
    !global_reset_n |-> serial_reset;
  endproperty
  a_ser_rst: assert property (p_ser_rst) else $error("serial reset not global");
  property p_ser_quiet;
    serial_powerdown [*2] |-> !serial_tx_edge && !serial_rx_edge;
  endproperty
  a_ser_quiet: assert property (p_ser_quiet) else $error("serial edge in powerdown");
  property p_ser_edge;
    $rose(serial_tx_line_clock) && !serial_reset |-> ##[1:3] serial_tx_edge ##1 !serial_tx_edge;
  endproperty
  a_ser_edge: assert property (p_ser_edge) else $error("serial edge missing");
  property p_qptr;
    queue_pointer_reset |=> !queue_pointer_reset;
  endproperty
  a_qptr: assert property (p_qptr) else $error("queue pulse too long");
  property p_scan;
    scan_port_reset == !test_port_reset_pin_n;
  endproperty
  a_scan: assert property (p_scan) else $error("scan reset wrong");
  property p_rmii_oe;
    reduced_interface_select [*3] |-> mii_pins.tx_oe_n && mii_pins.rx_oe_n;
  endproperty
  a_rmii_oe: assert property (p_rmii_oe) else $error("mii pins driven in rmii");
  property p_done;
    reset_done |-> gr_cnt >= RESET_SETTLE_CYCLES;
  endproperty
  a_done: assert property (p_done) else $error("reset done too early");

  // main scenarios reached
  c_qptr: cover property (queue_pointer_reset);
  c_swrst: cover property (!global_reset_n);
  c_done: cover property ($rose(reset_done));
endmodule

bind mcrc_clock_reset mcrc_clock_reset_properties #(
  .RESET_SETTLE_CYCLES(RESET_SETTLE_CYCLES)
) u_props (
  .aclk, .aresetn, .reduced_interface_select, .test_port_reset_pin_n, .serial_tx_line_clock,
  .divided_reference_out, .management_clock_out, .mii_pins, .serial_tx_edge, .serial_rx_edge,
  .global_reset_n, .low_power, .serial_reset, .serial_powerdown, .queue_pointer_reset,
  .scan_port_reset, .host_bus_oe_n, .reset_done
);
`default_nettype wire

// ---- verif/test_mcrc_clock_reset.sv ----
// Purpose: self-checking bench for the mapper clock and reset block
// Assumes: settle count shortened to 20 cycles, registers on axi4-lite
// Notes:   clocks judged by rising-edge counts in windows
`timescale 1ns/100ps
`default_nettype none
module test_mcrc_clock_reset
  import mcrc_pkg::*;
;
  localparam int         SETTLE = 20;
  localparam logic [1:0] OK     = 2'h0;
  localparam logic [1:0] ERR    = 2'h2;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [9:0]  s_axi_awaddr = 10'h000;
  logic [9:0]  s_axi_araddr = 10'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        ris = 1'b0;
  logic [1:0]  style = 2'h0;
  logic        scan_n = 1'b1;
  logic        ser_run = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        refin, txin, rxin, stx, srx;
  logic        memory_clock_out, divided_reference_out, management_clock_out;
  logic        mac_tx_timing, mac_rx_timing, serial_tx_edge, serial_rx_edge;
  logic        global_reset_n, low_power, serial_reset, serial_powerdown, queue_pointer_reset;
  logic        scan_port_reset, host_bus_oe_n, host_bus_intel, host_bus_motorola, reset_done;
  mcrc_mii_pins_t mii_pins;
  int          fails = 0;
  int          n_compared = 0;
  int          qp_n = 0;

  mcrc_clock_reset #(.RESET_SETTLE_CYCLES(SETTLE)) dut (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .reduced_interface_select(ris),
    .host_bus_style_select(style), .test_port_reset_pin_n(scan_n), .reference_clock_in(refin),
    .serial_tx_line_clock(stx), .serial_rx_line_clock(srx), .memory_clock_out,
    .divided_reference_out, .management_clock_out, .mii_tx_clk_in(txin), .mii_rx_clk_in(rxin),
    .mii_pins, .mac_tx_timing, .mac_rx_timing, .serial_tx_edge, .serial_rx_edge,
    .global_reset_n, .low_power, .serial_reset, .serial_powerdown, .queue_pointer_reset,
    .scan_port_reset, .host_bus_oe_n, .host_bus_intel, .host_bus_motorola, .reset_done);
  mcrc_far_model u_far (.aclk, .run(ser_run), .ref_clk(refin), .phy_tx(txin), .phy_rx(rxin),
    .ser_tx(stx), .ser_rx(srx));
  // clock and queue pulse tally
  initial
  begin
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) if (queue_pointer_reset === 1'b1) qp_n <= qp_n + 1;

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic quit();
    fails++;
    $display("ERROR %0t wait ran out", $time);
    summarize();
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t response %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_near(input int got, input int exp);
    n_compared++;
    if (got < exp - (exp > 0) || got > exp + (exp > 0))
    begin
      fails++;
      $display("ERROR %0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  // axi4-lite write, address and data offered together
  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 200; k++)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (k == 200) quit();
    chk_resp(s_axi_bresp, er);
  endtask
  // axi4-lite read and compare
  task automatic rchk(input logic [9:0] a, input logic [31:0] ed, input logic [1:0] er);
    int k;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 200; k++)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (k == 200) quit();
    chk_val(s_axi_rdata, ed);
    chk_resp(s_axi_rresp, er);
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return divided_reference_out;
      1: return mii_pins.tx_out;
      2: return serial_tx_edge;
      3: return management_clock_out;
      4: return mac_tx_timing;
      default: return mac_rx_timing;
    endcase
  endfunction
  // count rising edges of one output over a window after settling
  task automatic meas(input int s, input int nc, input int exp);
    logic p;
    int n;
    repeat (4) @(posedge aclk);
    #1 p = pick(s);
    n = 0;
    repeat (nc)
    begin
      @(posedge aclk);
      #1 n += (pick(s) && !p);
      p = pick(s);
    end
    chk_near(n + 1000 * $isunknown(p), exp);
  endtask
  // hang guard
  initial
  begin
    repeat (100000) @(posedge aclk);
    quit();
  end

  // main sequence
  initial
  begin
    int q0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (SETTLE + 10) @(posedge aclk);
    for (int i = 0; i < 2; i++)
    begin
      style <= 2'(i);
      repeat (3) @(posedge aclk);
      rchk(10'h0fc, (i != 0) ? 32'h4a : 32'h28, OK);
      chk_val({host_bus_motorola, host_bus_intel}, (i != 0) ? 2 : 1);
    end
    style <= 2'h0;
    rchk(10'h0f0, 0, OK);
    rchk(10'h0ec, 0, ERR);
    wr(10'h100, 1, ERR);
    $display("test registers done");
    @(posedge aclk);
    #2 chk_val(memory_clock_out, 1);
    #4 chk_val(memory_clock_out, 0);
    meas(0, 400, 100);
    meas(3, 740, 10);
    wr(10'h0f0, 2, OK);
    meas(0, 400, 0);
    chk_val(divided_reference_out, 0);
    wr(10'h0f0, 12, OK);
    meas(1, 400, 100);
    chk_val({mii_pins.tx_oe_n, mii_pins.rx_oe_n}, 0);
    wr(10'h0f0, 4, OK);
    meas(1, 400, 10);
    wr(10'h0f0, 0, OK);
    meas(4, 400, 50);
    meas(5, 400, 50);
    chk_val({mii_pins.tx_oe_n, mii_pins.rx_oe_n}, 3);
    ris <= 1'b1;
    meas(0, 400, 200);
    meas(4, 400, 100);
    ris <= 1'b0;
    $display("test clocks done");
    ser_run <= 1'b1;
    meas(2, 640, 30);
    ser_run <= 1'b0;
    wr(10'h0f4, 1, OK);
    rchk(10'h0f4, 1, OK);
    chk_val({serial_powerdown, serial_reset}, 3);
    ser_run <= 1'b1;
    meas(2, 640, 0);
    ser_run <= 1'b0;
    wr(10'h0f4, 0, OK);
    $display("test serial done");
    q0 = qp_n;
    wr(10'h0f8, 1, OK);
    s_axi_wstrb <= 4'h0;
    wr(10'h0f8, 1, OK);
    s_axi_wstrb <= 4'hf;
    repeat (2) @(posedge aclk);
    chk_val(qp_n - q0, 1);
    rchk(10'h0f8, 0, OK);
    scan_n <= 1'b0;
    @(posedge aclk);
    #1 chk_val({scan_port_reset, global_reset_n}, 3);
    scan_n <= 1'b1;
    $display("test queue done");
    wr(10'h0f4, 1, OK);
    wr(10'h0f0, 3, OK);
    repeat (2) @(posedge aclk);
    chk_val({global_reset_n, low_power}, 1);
    rchk(10'h0f0, 1, OK);
    rchk(10'h0f4, 0, OK);
    rchk(10'h0fc, 32'h30, OK);
    meas(0, 40, 0);
    wr(10'h0f0, 0, OK);
    #1 chk_val({global_reset_n, reset_done}, 2);
    repeat (SETTLE + 4) @(posedge aclk);
    #1 chk_val(reset_done, 1);
    wr(10'h0f0, 1, OK);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    #1 chk_val({host_bus_oe_n, low_power}, 3);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rchk(10'h0f0, 0, OK);
    $display("test reset done");
    summarize();
  end
endmodule
`default_nettype wire
